// file: rtl/smw_regs.svh
`ifndef SMW_REGS_SVH
`define SMW_REGS_SVH
// register addresses on the plain register port
`define SMW_ADDR_TBL_LOW 3'h0
`define SMW_ADDR_WAKE 3'h1
`define SMW_ADDR_MODE 3'h2
`define SMW_ADDR_ISR1 3'h3
`define SMW_ADDR_IRC 3'h4
`define SMW_ADDR_IMASK1 3'h5
// implemented bit masks; all other bits read zero
`define SMW_WAKE_MASK 8'hF0
`define SMW_MODE_MASK 8'h70
`define SMW_ISR1_MASK 8'h47
`define SMW_IRC_MASK 8'hC0
// field positions
`define SMW_WAKE_CMP2 7
`define SMW_WAKE_PORT 6
`define SMW_WAKE_ADC 5
`define SMW_WAKE_EXT 4
`define SMW_MODE_TIMER 6
`define SMW_MODE_CPU 5
`define SMW_MODE_IDLE 4
`define SMW_FLAG_ADC 6
`define SMW_FLAG_EXT 2
`define SMW_FLAG_PORT 1
`define SMW_FLAG_TMR 0
`define SMW_IRC_LSB 6
`define SMW_CFG_OVR 12
`define SMW_CFG_IRC_LSB 2
// reset values
`define SMW_RST_BYTE 8'h00
`define SMW_RST_MODE 8'h60
// timing
`define SMW_WAIT_XTAL 9'd254
`define SMW_WAIT_OTHER 9'd32
`define SMW_STABLE_4M_NS 5000
`define SMW_STABLE_16M_NS 1500
`define SMW_STABLE_8M_NS 3000
`define SMW_CLK_NS 10
`endif

// file: rtl/smw_pkg.sv
package smw_pkg;
   typedef enum logic [1:0] {
      SMW_IRC_4M = 2'h0,
      SMW_IRC_16M = 2'h1,
      SMW_IRC_8M = 2'h2,
      SMW_IRC_BAD = 2'h3
   } smw_irc_t;
   typedef enum logic [1:0] {
      SMW_RUN = 2'h0,
      SMW_STOPPED = 2'h1,
      SMW_COUNT = 2'h3
   } smw_state_t;
   typedef struct packed {
      logic adc_done;
      logic ext_fall;
      logic port_change;
      logic timer_ovf;
      logic cmp2_change;
   } smw_evt_t;
endpackage

// file: rtl/smw_ctrl.sv
`timescale 1ns/100ps
`include "smw_regs.svh"
// How it works
// - table pointer low holds code address bits; increment overflow carries up
// - decrement underflow borrows one from the high pointer
// - comparator 2 change wakes only with its enable set; it sets no flag
// - port 6 change wake gated by its enable bit
// - adc complete wake gated by its enable bit
// - external pin wake gated by its enable bit
// - unused bits always read zero
// - mode bit 6 picks timer clock: 0 sub, 1 main
// - mode bit 5 picks cpu clock; 0 also stops main oscillator
// - sleep instruction enters idle if bit 4 set, else sleep
// - after stable oscillator, count 254 (crystal to normal) else 32 clocks
// - adc done sets flag bit 6, software clears
// - falling external pin edge sets flag bit 2
// - port 6 change sets flag bit 1
// - timer 0 overflow sets flag bit 0
// - software only clears flags, never sets
// - flag read returns flags anded with mask register
// - irc select acts only when config word bit 12 is one
// - irc code 00 4 MHz, 01 16 MHz, 10 8 MHz, 11 invalid
// - irc select loads config word bits 3..2 at init
// - irc change holds cpu for new frequency stable time
module smw_ctrl (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // table pointer steps from the table read sequencer
   input wire logic tbl_inc,
   input wire logic tbl_dec,
   output logic tbl_carry,
   output logic tbl_borrow,
   // event sources (same clock) and external pin (asynchronous)
   input wire smw_pkg::smw_evt_t evt,
   input wire logic ext_int_n_pin,
   // core status
   input wire logic sleep_instruction,
   input wire logic osc_stable,
   input wire logic crystal_osc,
   input wire logic [15:0] config_word_one,
   // outputs
   output logic timer_clock_select,
   output logic cpu_clock_select,
   output logic main_osc_stop,
   output logic idle_mode,
   output logic sleep_mode,
   output logic wake_up,
   output logic cpu_hold,
   output logic [1:0] irc_mode,
   output logic irc_mode_active
);
   localparam int STABLE_4M = (`SMW_STABLE_4M_NS + `SMW_CLK_NS - 1) / `SMW_CLK_NS;
   localparam int STABLE_16M = (`SMW_STABLE_16M_NS + `SMW_CLK_NS - 1) / `SMW_CLK_NS;
   localparam int STABLE_8M = (`SMW_STABLE_8M_NS + `SMW_CLK_NS - 1) / `SMW_CLK_NS;

   function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
      hit = (a == r);
   endfunction

   logic [7:0] table_pointer_low_r;
   logic [7:0] wake_control_r;
   logic [7:0] mode_select_r;
   logic [7:0] isr_one_r;
   logic [7:0] irc_select_r;
   logic [7:0] interrupt_mask_one_r;
   logic [7:0] flag_set;
   logic [7:0] rd_nxt;
   logic ext_meta_r;
   logic ext_sync_r;
   logic ext_prev_r;
   logic ext_fall;
   logic wake_req;
   logic init_done_r;
   logic [9:0] irc_cnt_r;
   logic [8:0] wake_cnt_r;
   smw_pkg::smw_state_t state_r;

   // two-stage synchroniser; edge detect compares the second stage with its one-cycle-delayed copy
   always_ff @(posedge core_clk) begin
      ext_meta_r <= ext_int_n_pin;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
   end
   assign ext_fall = ext_prev_r & ~ext_sync_r;

   // table pointer low with carry and borrow out
   always_ff @(posedge core_clk) begin
      if (srst) begin
         table_pointer_low_r <= `SMW_RST_BYTE;
         tbl_carry <= 1'b0;
         tbl_borrow <= 1'b0;
      end else begin
         tbl_carry <= tbl_inc && (table_pointer_low_r == 8'hFF);
         tbl_borrow <= tbl_dec && !tbl_inc && (table_pointer_low_r == 8'h00);
         if (reg_wr && hit(reg_addr, `SMW_ADDR_TBL_LOW)) begin
            table_pointer_low_r <= reg_wdata;
         end else if (tbl_inc) begin
            table_pointer_low_r <= table_pointer_low_r + 8'h01;
         end else if (tbl_dec) begin
            table_pointer_low_r <= table_pointer_low_r - 8'h01;
         end
      end
   end

   // control registers; unused bits never stored
   always_ff @(posedge core_clk) begin
      if (srst) begin
         wake_control_r <= `SMW_RST_BYTE;
         mode_select_r <= `SMW_RST_MODE;
         interrupt_mask_one_r <= `SMW_RST_BYTE;
      end else if (reg_wr) begin
         if (hit(reg_addr, `SMW_ADDR_WAKE)) begin
            wake_control_r <= reg_wdata & `SMW_WAKE_MASK;
         end
         if (hit(reg_addr, `SMW_ADDR_MODE)) begin
            mode_select_r <= reg_wdata & `SMW_MODE_MASK;
         end
         if (hit(reg_addr, `SMW_ADDR_IMASK1)) begin
            interrupt_mask_one_r <= reg_wdata & `SMW_ISR1_MASK;
         end
      end
   end

   // interrupt flags: hardware sets, software writes 0 to clear; set wins
   always_comb begin
      flag_set = 8'h00;
      flag_set[`SMW_FLAG_ADC] = evt.adc_done;
      flag_set[`SMW_FLAG_EXT] = ext_fall;
      flag_set[`SMW_FLAG_PORT] = evt.port_change;
      flag_set[`SMW_FLAG_TMR] = evt.timer_ovf;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         isr_one_r <= `SMW_RST_BYTE;
      end else if (reg_wr && hit(reg_addr, `SMW_ADDR_ISR1)) begin
         isr_one_r <= ((isr_one_r & reg_wdata) | flag_set) & `SMW_ISR1_MASK;
      end else begin
         isr_one_r <= (isr_one_r | flag_set) & `SMW_ISR1_MASK;
      end
   end

   // irc select: loaded from config at init, then software may change it
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irc_select_r <= `SMW_RST_BYTE;
         init_done_r <= 1'b0;
      end else if (!init_done_r) begin
         irc_select_r <= {config_word_one[`SMW_CFG_IRC_LSB +: 2], 6'h00};
         init_done_r <= 1'b1;
      end else if (reg_wr && hit(reg_addr, `SMW_ADDR_IRC)) begin
         irc_select_r <= reg_wdata & `SMW_IRC_MASK;
      end
   end
   assign irc_mode_active = config_word_one[`SMW_CFG_OVR];
   assign irc_mode = irc_select_r[`SMW_IRC_LSB +: 2];

   // hold after an irc change for the stable time of the new frequency
   always_ff @(posedge core_clk) begin
      if (srst) begin
         irc_cnt_r <= 10'h000;
      end else if (init_done_r && irc_mode_active && reg_wr
                   && hit(reg_addr, `SMW_ADDR_IRC)
                   && reg_wdata[`SMW_IRC_LSB +: 2] != irc_mode) begin
         unique case (smw_pkg::smw_irc_t'(reg_wdata[`SMW_IRC_LSB +: 2]))
            smw_pkg::SMW_IRC_4M: irc_cnt_r <= 10'(STABLE_4M);
            smw_pkg::SMW_IRC_16M: irc_cnt_r <= 10'(STABLE_16M);
            smw_pkg::SMW_IRC_8M: irc_cnt_r <= 10'(STABLE_8M);
            smw_pkg::SMW_IRC_BAD: irc_cnt_r <= 10'h000;
         endcase
      end else if (irc_cnt_r != 10'h000) begin
         irc_cnt_r <= irc_cnt_r - 10'h001;
      end
   end

   // gated wake sources
   assign wake_req = (evt.cmp2_change & wake_control_r[`SMW_WAKE_CMP2])
      | (evt.port_change & wake_control_r[`SMW_WAKE_PORT])
      | (evt.adc_done & wake_control_r[`SMW_WAKE_ADC])
      | (ext_fall & wake_control_r[`SMW_WAKE_EXT]);

   // power state: run, stopped (sleep or idle), then wake count
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_r <= smw_pkg::SMW_RUN;
         idle_mode <= 1'b0;
         wake_cnt_r <= 9'h000;
      end else begin
         unique case (state_r)
            smw_pkg::SMW_RUN: begin
               if (sleep_instruction) begin
                  idle_mode <= mode_select_r[`SMW_MODE_IDLE];
                  state_r <= smw_pkg::SMW_STOPPED;
               end
            end
            smw_pkg::SMW_STOPPED: begin
               if (wake_req) begin
                  state_r <= smw_pkg::SMW_COUNT;
                  wake_cnt_r <= 9'h000;
               end
            end
            smw_pkg::SMW_COUNT: begin
               if (osc_stable) begin
                  wake_cnt_r <= wake_cnt_r + 9'h001;
                  if (wake_cnt_r + 9'h001 >= ((crystal_osc && mode_select_r[`SMW_MODE_CPU])
                      ? `SMW_WAIT_XTAL : `SMW_WAIT_OTHER)) begin
                     state_r <= smw_pkg::SMW_RUN;
                     idle_mode <= 1'b0;
                  end
               end
            end
            default: state_r <= smw_pkg::SMW_RUN;
         endcase
      end
   end

   assign sleep_mode = (state_r == smw_pkg::SMW_STOPPED) && !idle_mode;
   assign wake_up = (state_r == smw_pkg::SMW_STOPPED) && wake_req;
   assign cpu_hold = (state_r != smw_pkg::SMW_RUN) || (irc_cnt_r != 10'h000);
   assign timer_clock_select = mode_select_r[`SMW_MODE_TIMER];
   assign cpu_clock_select = mode_select_r[`SMW_MODE_CPU];
   assign main_osc_stop = !mode_select_r[`SMW_MODE_CPU] || sleep_mode;

   // read mux
   always_comb begin
      unique case (reg_addr)
         `SMW_ADDR_TBL_LOW: rd_nxt = table_pointer_low_r;
         `SMW_ADDR_WAKE: rd_nxt = wake_control_r;
         `SMW_ADDR_MODE: rd_nxt = mode_select_r;
         `SMW_ADDR_ISR1: rd_nxt = isr_one_r & interrupt_mask_one_r;
         `SMW_ADDR_IRC: rd_nxt = irc_select_r;
         `SMW_ADDR_IMASK1: rd_nxt = interrupt_mask_one_r;
         default: rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_nxt;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

// file: test/smw_ctrl_asserts.sv
`timescale 1ns/100ps
`include "smw_regs.svh"
module smw_ctrl_asserts (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // table pointer
   input wire logic tbl_inc,
   input wire logic tbl_dec,
   input wire logic tbl_carry,
   input wire logic tbl_borrow,
   // config word, status and mode outputs
   input wire logic [15:0] config_word_one,
   input wire logic irc_mode_active,
   input wire logic timer_clock_select,
   input wire logic cpu_clock_select,
   input wire logic main_osc_stop,
   input wire logic idle_mode,
   input wire logic sleep_mode,
   input wire logic wake_up,
   input wire logic cpu_hold
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);
   // read data must not linger past its one cycle
   a_read_quiet: assert property ((!$past(reg_rd) || $past(reg_addr) > 3'h5) |-> reg_rdata == 8'h00)
      else $error("read data not zero");
   a_wake_spare: assert property ($past(reg_rd) && $past(reg_addr) == `SMW_ADDR_WAKE |-> reg_rdata[3:0] == 4'h0)
      else $error("wake spare bits set");
   a_carry_cause: assert property (tbl_carry |-> $past(tbl_inc))
      else $error("carry without increment");
   a_borrow_cause: assert property (tbl_borrow |-> $past(tbl_dec) && !$past(tbl_inc))
      else $error("borrow without decrement");
   a_irc_enable: assert property (irc_mode_active == config_word_one[`SMW_CFG_OVR])
      else $error("irc enable mismatch");
   a_main_stop: assert property (!cpu_clock_select |-> main_osc_stop)
      else $error("main oscillator runs on sub clock");
   a_mode_write: assert property ($past(reg_wr) && $past(reg_addr) == `SMW_ADDR_MODE
      |-> {timer_clock_select, cpu_clock_select} == $past(reg_wdata[6:5]))
      else $error("clock selects not from mode write");
   a_sleep_hold: assert property (sleep_mode |-> cpu_hold)
      else $error("cpu runs in sleep");
   a_mode_excl: assert property (!(sleep_mode && idle_mode))
      else $error("idle and sleep together");
   a_wake_count: assert property (wake_up |=> cpu_hold)
      else $error("no hold after wake");
   c_carry: cover property (tbl_carry);
   c_wake: cover property (wake_up);
   c_resume: cover property ($fell(cpu_hold));
endmodule
bind smw_ctrl smw_ctrl_asserts smw_ctrl_asserts_inst (.core_clk(core_clk), .srst(srst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .tbl_inc(tbl_inc), .tbl_dec(tbl_dec), .tbl_carry(tbl_carry),
   .tbl_borrow(tbl_borrow), .config_word_one(config_word_one),
   .irc_mode_active(irc_mode_active), .timer_clock_select(timer_clock_select),
   .cpu_clock_select(cpu_clock_select), .main_osc_stop(main_osc_stop),
   .idle_mode(idle_mode), .sleep_mode(sleep_mode), .wake_up(wake_up), .cpu_hold(cpu_hold));

// file: test/smw_ctrl_tb.sv
`timescale 1ns/100ps
`include "smw_regs.svh"
module smw_ctrl_tb;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic tbl_inc = 1'b0;
   logic tbl_dec = 1'b0;
   smw_pkg::smw_evt_t evt = '0;
   logic ext_int_n_pin = 1'b1;
   logic sleep_instruction = 1'b0;
   logic crystal_osc = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] irc_mode;
   logic tbl_carry, tbl_borrow, timer_clock_select, cpu_clock_select, main_osc_stop;
   logic idle_mode, sleep_mode, wake_up, cpu_hold, irc_mode_active;
   int n_errors = 0;
   int checks = 0;
   always #5 core_clk = ~core_clk;
   // oscillator always stable; crystal source toggled by the sleep scenario
   smw_ctrl smw_ctrl_inst (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tbl_inc(tbl_inc), .tbl_dec(tbl_dec), .tbl_carry(tbl_carry), .tbl_borrow(tbl_borrow),
      .evt(evt), .ext_int_n_pin(ext_int_n_pin), .sleep_instruction(sleep_instruction),
      .osc_stable(1'b1), .crystal_osc(crystal_osc), .config_word_one(16'h1008),
      .timer_clock_select(timer_clock_select), .cpu_clock_select(cpu_clock_select),
      .main_osc_stop(main_osc_stop), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
      .wake_up(wake_up), .cpu_hold(cpu_hold), .irc_mode(irc_mode),
      .irc_mode_active(irc_mode_active));
   task conclude;
      if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task cmpb(input logic got, input logic exp);
      cmp({7'h00, got}, {7'h00, exp});
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 cmp(reg_rdata, e);
   endtask
   // bounded so a stuck hold cannot hang the run
   task hold_len(output int n);
      n = 0;
      // let the edge that started the hold update its counters first
      #1;
      while (cpu_hold !== 1'b0 && n < 1000) begin
         @(posedge core_clk);
         #1 n++;
      end
   endtask
   task t_reset;
      rd(`SMW_ADDR_MODE, `SMW_RST_MODE);
      rd(`SMW_ADDR_WAKE, 8'h00);
      rd(`SMW_ADDR_IRC, 8'h80);
      cmp({6'h00, irc_mode}, 8'h02);
      cmpb(timer_clock_select, 1'b1);
      cmpb(cpu_clock_select, 1'b1);
      cmpb(main_osc_stop, 1'b0);
      cmpb(irc_mode_active, 1'b1);
   endtask
   task t_spare;
      wr(`SMW_ADDR_WAKE, 8'hFF);
      rd(`SMW_ADDR_WAKE, 8'hF0);
      wr(`SMW_ADDR_MODE, 8'hFF);
      rd(`SMW_ADDR_MODE, 8'h70);
      wr(3'h7, 8'hFF);
      rd(3'h7, 8'h00);
      wr(`SMW_ADDR_MODE, 8'h60);
   endtask
   task t_table;
      wr(`SMW_ADDR_TBL_LOW, 8'hFF);
      @(posedge core_clk) tbl_inc <= 1'b1;
      @(posedge core_clk) tbl_inc <= 1'b0;
      #1 cmpb(tbl_carry, 1'b1);
      rd(`SMW_ADDR_TBL_LOW, 8'h00);
      @(posedge core_clk) tbl_dec <= 1'b1;
      @(posedge core_clk) tbl_dec <= 1'b0;
      #1 cmpb(tbl_borrow, 1'b1);
      rd(`SMW_ADDR_TBL_LOW, 8'hFF);
   endtask
   task t_flags;
      wr(`SMW_ADDR_IMASK1, 8'hFF);
      @(posedge core_clk) evt <= 5'h16;
      ext_int_n_pin <= 1'b0;
      @(posedge core_clk) evt <= '0;
      repeat (4) @(posedge core_clk);
      rd(`SMW_ADDR_ISR1, 8'h47);
      wr(`SMW_ADDR_ISR1, 8'hFF);
      rd(`SMW_ADDR_ISR1, 8'h47);
      wr(`SMW_ADDR_ISR1, 8'hBE);
      rd(`SMW_ADDR_ISR1, 8'h06);
      wr(`SMW_ADDR_IMASK1, 8'h02);
      rd(`SMW_ADDR_ISR1, 8'h02);
      wr(`SMW_ADDR_ISR1, 8'h00);
      wr(`SMW_ADDR_IMASK1, 8'hFF);
      rd(`SMW_ADDR_ISR1, 8'h00);
   endtask
   task t_sleep;
      int n;
      wr(`SMW_ADDR_WAKE, 8'h00);
      @(posedge core_clk) sleep_instruction <= 1'b1;
      ext_int_n_pin <= 1'b1;
      @(posedge core_clk) sleep_instruction <= 1'b0;
      evt <= 5'h10;
      #1 cmpb(sleep_mode, 1'b1);
      cmpb(wake_up, 1'b0);
      @(posedge core_clk) evt <= '0;
      wr(`SMW_ADDR_WAKE, 8'h20);
      @(posedge core_clk) evt <= 5'h10;
      #1 cmpb(wake_up, 1'b1);
      @(posedge core_clk) evt <= '0;
      hold_len(n);
      cmpb(n >= 30 && n <= 34, 1'b1);
      crystal_osc <= 1'b1;
      wr(`SMW_ADDR_MODE, 8'h70);
      @(posedge core_clk) sleep_instruction <= 1'b1;
      @(posedge core_clk) sleep_instruction <= 1'b0;
      #1 cmpb(idle_mode, 1'b1);
      cmpb(sleep_mode, 1'b0);
      @(posedge core_clk) evt <= 5'h10;
      @(posedge core_clk) evt <= '0;
      hold_len(n);
      cmpb(n >= 252 && n <= 256, 1'b1);
      crystal_osc <= 1'b0;
      wr(`SMW_ADDR_MODE, 8'h60);
   endtask
   task t_irc;
      logic [7:0] code [4];
      int span [4];
      int n;
      // the invalid code is last: it must not hold the cpu at all
      code = '{8'h40, 8'h80, 8'h00, 8'hC0};
      span = '{150, 300, 500, 0};
      for (int i = 0; i < 4; i++) begin
         wr(`SMW_ADDR_IRC, code[i]);
         hold_len(n);
         cmpb(n >= span[i] - 2 && n <= span[i] + 2, 1'b1);
         rd(`SMW_ADDR_IRC, code[i]);
      end
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      t_reset;
      t_spare;
      t_table;
      t_flags;
      t_sleep;
      t_irc;
      conclude;
   end
   initial begin
      #100000;
      n_errors++;
      conclude;
   end
endmodule
